// ==== hdl/scc_consts.svh ====
/*
 Timing counts, field widths and reset values for the coil chopper.
 Assumes inclusion by bare name from the package and the design files.
*/
// How it works
// [RULE1] signed voltage-scaling readback is read-only and frozen in current mode
// [RULE2] auto gradient and offset readbacks are read-only, zero to maximum
// [RULE3] off time zero switches the driver off; any nonzero value enables it
// [RULE4] blank select codes 0..3 give 16, 24, 32, 40 clock masking
// [RULE5] each slow-decay phase ends by its timer, never by the comparator
// [RULE6] the on phase ends when the comparator reports target current reached
// [RULE7] fast decay ends on comparator trip or fast-decay timer, whichever first
// [RULE8] comparator is masked for the blank time after every bridge switch
// [RULE9] current mode runs on, slow decay, fast decay, second slow decay
// [RULE10] each coil has its own chopper machine with no shared timing
// [RULE11] settings should give roughly 16 to 30 kHz chopper frequency
// [RULE12] slow decay lasts 12 plus 32 clocks per off time unit
// [RULE13] mode pin xor mode flag: 1 current chopper, 0 voltage mode
// [RULE14] after second slow decay, a new on phase starts with fresh blanking
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH
`define SCC_CLK_MHZ 25
`define SCC_SLOW_BASE 12
`define SCC_SLOW_STEP 32
`define SCC_BLANK_BASE 16
`define SCC_BLANK_STEP 8
`define SCC_OFF_W 4
`define SCC_TMR_W 10
`define SCC_FAST_RST 8'h40
`define SCC_SCALE_RST 9'h000
`define SCC_AMP_RST 8'h00
`endif

// ==== hdl/scc_pkg.sv ====
/*
 Types shared by the coil chopper modules.
 Assumes scc_consts.svh is on the include path.
*/
`include "scc_consts.svh"
package scc_pkg;
    typedef enum logic [2:0] {
        SCC_IDLE = 3'b000,
        SCC_ON = 3'b001,
        SCC_SLOW1 = 3'b010,
        SCC_FAST = 3'b011,
        SCC_SLOW2 = 3'b100
    } scc_phase_t;
    // shared chopper settings, same for both coils
    typedef struct packed {
        logic enable;
        logic cur_mode;
        logic [`SCC_OFF_W-1:0] off_time;
        logic [1:0] blank_sel;
        logic [7:0] fast_time;
    } scc_cfg_t;
    // bridge drive for one coil
    typedef struct packed {
        logic drive_on;
        logic slow_decay;
        logic fast_decay;
    } scc_bridge_t;
endpackage

// ==== hdl/scc_coil.sv ====
/*
 One coil chopper: sequences the bridge through its four phases.
 Assumes the comparator input is already synchronised to CLK.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scc_consts.svh"
module scc_coil
    import scc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire scc_cfg_t cfg,
    input wire logic comp_trip,
    output scc_bridge_t bridge,
    output scc_phase_t phase,
    output logic blanking
);
    scc_phase_t phase_q, phase_d;
    logic [`SCC_TMR_W-1:0] tmr_q, tmr_d;
    logic [5:0] blank_q, blank_d;
    logic sw;
    logic trip;

    // blank length in clocks for a select code
    function automatic logic [5:0] blank_len(input logic [1:0] sel);
        blank_len = 6'(`SCC_BLANK_BASE + `SCC_BLANK_STEP * sel); // [RULE4]
    endfunction

    // slow decay length for an off time value
    function automatic logic [`SCC_TMR_W-1:0] slow_len(
        input logic [`SCC_OFF_W-1:0] off);
        slow_len = `SCC_TMR_W'(`SCC_SLOW_BASE + `SCC_SLOW_STEP * off); // [RULE12]
    endfunction

    // comparator is only believed outside blanking
    assign trip = comp_trip && (blank_q == 6'h00); // [RULE8]

    // phase sequencing; the timer is reloaded on entry to each decay phase
    always_comb begin
        phase_d = phase_q;
        tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
        sw = 1'b0;
        if (!cfg.enable || !cfg.cur_mode) begin // [RULE3] [RULE13]
            phase_d = SCC_IDLE;
        end else begin
            unique case (phase_q)
                SCC_IDLE: begin
                    phase_d = SCC_ON;
                    sw = 1'b1;
                end
                SCC_ON: if (trip) begin // [RULE6]
                    phase_d = SCC_SLOW1; // [RULE9]
                    tmr_d = slow_len(cfg.off_time) - 1'b1;
                    sw = 1'b1;
                end
                SCC_SLOW1: if (tmr_q == '0) begin // [RULE5]
                    phase_d = SCC_FAST;
                    tmr_d = {2'b00, cfg.fast_time};
                    sw = 1'b1;
                end
                SCC_FAST: if (trip || tmr_q == '0) begin // [RULE7]
                    phase_d = SCC_SLOW2;
                    tmr_d = slow_len(cfg.off_time) - 1'b1;
                    sw = 1'b1;
                end
                SCC_SLOW2: if (tmr_q == '0) begin // [RULE5]
                    phase_d = SCC_ON; // [RULE14]
                    sw = 1'b1;
                end
                default: phase_d = SCC_IDLE;
            endcase
        end
    end

    // blank counter restarts on every switching event
    always_comb begin
        if (sw) begin
            blank_d = blank_len(cfg.blank_sel); // [RULE8]
        end else if (blank_q != 6'h00) begin
            blank_d = blank_q - 6'h01;
        end else begin
            blank_d = blank_q;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= SCC_IDLE;
            tmr_q <= '0;
            blank_q <= 6'h00;
        end else begin
            phase_q <= phase_d;
            tmr_q <= tmr_d;
            blank_q <= blank_d;
        end
    end

    // bridge drive registered from the next phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bridge <= '0;
        end else begin
            bridge.drive_on <= (phase_d == SCC_ON);
            bridge.slow_decay <= (phase_d == SCC_SLOW1)
                || (phase_d == SCC_SLOW2);
            bridge.fast_decay <= (phase_d == SCC_FAST);
        end
    end

    assign phase = phase_q;
    assign blanking = (blank_q != 6'h00);
endmodule
`default_nettype wire

// ==== hdl/scc_top.sv ====
/*
 Two-coil chopper control with voltage-mode readbacks.
 Assumes comparator pins are asynchronous and the voltage regulator
 supplies its scaling and tuning values on CLK.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scc_consts.svh"
module scc_top
    import scc_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [`SCC_OFF_W-1:0] OFF_TIME_SETTING,
    input wire logic [1:0] BLANK_TIME_SELECT,
    input wire logic [7:0] FAST_DECAY_TIME,
    input wire logic MODE_PIN,
    input wire logic MODE_FLAG,
    input wire logic [1:0] COMP_TRIP,
    input wire logic [8:0] REG_SCALE,
    input wire logic [7:0] REG_GRADIENT,
    input wire logic [7:0] REG_OFFSET,
    output logic [1:0] DRIVE_ON,
    output logic [1:0] SLOW_DECAY,
    output logic [1:0] FAST_DECAY,
    output logic [1:0] BLANKING,
    output logic DRIVER_ENABLED,
    output logic CURRENT_MODE,
    output logic [8:0] AUTO_SCALE_READBACK,
    output logic [7:0] AUTO_GRADIENT_READBACK,
    output logic [7:0] AUTO_OFFSET_READBACK
);
    logic [2:0] comp_sync_q [2];
    logic [1:0] comp_q;
    logic [2:0] mode_sync_q;
    logic mode_q;
    scc_cfg_t cfg;
    scc_bridge_t bridge [2];

    // three-stage sync; change counts once stages two and three agree
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_sync_q <= 3'h0;
            mode_q <= 1'b0;
        end else begin
            mode_sync_q <= {mode_sync_q[1:0], MODE_PIN};
            if (mode_sync_q[1] == mode_sync_q[2]) begin
                mode_q <= mode_sync_q[2];
            end
        end
    end

    assign cfg.enable = (OFF_TIME_SETTING != '0); // [RULE3]
    assign cfg.cur_mode = mode_q ^ MODE_FLAG; // [RULE13]
    assign cfg.off_time = OFF_TIME_SETTING;
    assign cfg.blank_sel = BLANK_TIME_SELECT;
    assign cfg.fast_time = FAST_DECAY_TIME;

    // independent machines per coil, sharing only configuration
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_coil
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    comp_sync_q[g] <= 3'h0;
                    comp_q[g] <= 1'b0;
                end else begin
                    comp_sync_q[g] <= {comp_sync_q[g][1:0], COMP_TRIP[g]};
                    if (comp_sync_q[g][1] == comp_sync_q[g][2]) begin
                        comp_q[g] <= comp_sync_q[g][2];
                    end
                end
            end
            scc_coil u_coil ( // [RULE10]
                .clk(CLK),
                .reset_n(RESET_N),
                .cfg(cfg),
                .comp_trip(comp_q[g]),
                .bridge(bridge[g]),
                .phase(),
                .blanking(BLANKING[g])
            );
            assign DRIVE_ON[g] = bridge[g].drive_on;
            assign SLOW_DECAY[g] = bridge[g].slow_decay;
            assign FAST_DECAY[g] = bridge[g].fast_decay;
        end
    endgenerate

    // status flags registered for a clean readout
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DRIVER_ENABLED <= 1'b0;
            CURRENT_MODE <= 1'b0;
        end else begin
            DRIVER_ENABLED <= cfg.enable;
            CURRENT_MODE <= cfg.cur_mode;
        end
    end

    // scale readback frozen while the current chopper runs
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            AUTO_SCALE_READBACK <= `SCC_SCALE_RST;
        end else if (!cfg.cur_mode) begin // [RULE1]
            AUTO_SCALE_READBACK <= REG_SCALE;
        end
    end

    // tuning readbacks simply track the regulator, full 0..255 range
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            AUTO_GRADIENT_READBACK <= `SCC_AMP_RST;
            AUTO_OFFSET_READBACK <= `SCC_AMP_RST;
        end else begin
            AUTO_GRADIENT_READBACK <= REG_GRADIENT; // [RULE2]
            AUTO_OFFSET_READBACK <= REG_OFFSET; // [RULE2]
        end
    end
endmodule
`default_nettype wire

// ==== testbench/scc_top_asserts.sv ====
/*
 Port checker for the two-coil chopper, coil 0 phase sequencing.
 Assumes binding into every scc_top instance.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scc_consts.svh"
module scc_top_chk (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [`SCC_OFF_W-1:0] OFF_TIME_SETTING,
    input wire logic [7:0] REG_GRADIENT,
    input wire logic [1:0] DRIVE_ON,
    input wire logic [1:0] SLOW_DECAY,
    input wire logic [1:0] FAST_DECAY,
    input wire logic [1:0] BLANKING,
    input wire logic DRIVER_ENABLED,
    input wire logic CURRENT_MODE,
    input wire logic [8:0] AUTO_SCALE_READBACK,
    input wire logic [7:0] AUTO_GRADIENT_READBACK
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // readbacks
    property p_frz; CURRENT_MODE && $past(CURRENT_MODE)
        |-> $stable(AUTO_SCALE_READBACK); endproperty
    a_frz: assert property (p_frz) else $error("scale moved");
    property p_grd; 1 |=> AUTO_GRADIENT_READBACK == $past(REG_GRADIENT);
    endproperty
    a_grd: assert property (p_grd) else $error("gradient lag");
    // enable and bridge sequencing
    property p_off; OFF_TIME_SETTING == 4'h0 [*3]
        |-> !DRIVER_ENABLED && DRIVE_ON == 2'h0; endproperty
    a_off: assert property (p_off) else $error("driver not off");
    property p_blk; $rose(DRIVE_ON[0]) |-> (BLANKING[0] || !DRIVE_ON[0]) [*8];
    endproperty
    a_blk: assert property (p_blk) else $error("no blanking");
    property p_blk1; $rose(SLOW_DECAY[1]) |-> BLANKING[1]; endproperty
    a_blk1: assert property (p_blk1) else $error("coil 1 no blank");
    property p_sl; $rose(SLOW_DECAY[0])
        |-> $past(DRIVE_ON[0]) || $past(FAST_DECAY[0]); endproperty
    a_sl: assert property (p_sl) else $error("slow order");
    property p_fs; $rose(FAST_DECAY[0]) |-> $past(SLOW_DECAY[0]); endproperty
    a_fs: assert property (p_fs) else $error("fast order");
    // a tripped comparator must not cut slow decay short
    property p_sln; $rose(SLOW_DECAY[0]) |->
        (SLOW_DECAY[0] || !CURRENT_MODE || !DRIVER_ENABLED) [*8]; endproperty
    a_sln: assert property (p_sln) else $error("slow cut short");
    property p_one; $onehot0({DRIVE_ON[1], SLOW_DECAY[1], FAST_DECAY[1]});
    endproperty
    a_one: assert property (p_one) else $error("bridge not one-hot");
endmodule
bind scc_top scc_top_chk u_scc_top_chk (.CLK, .RESET_N, .OFF_TIME_SETTING,
    .REG_GRADIENT, .DRIVE_ON, .SLOW_DECAY, .FAST_DECAY, .BLANKING,
    .DRIVER_ENABLED, .CURRENT_MODE, .AUTO_SCALE_READBACK,
    .AUTO_GRADIENT_READBACK);
`default_nettype wire

// ==== testbench/scc_bridge_model.sv ====
/*
 Behavioural coil and sense comparator for one bridge.
 Assumes bridge drive levels on the same clock as the chopper.
*/
`timescale 1ns/10ps
`default_nettype none
module scc_bridge_model #(parameter int LIM = 60) (
    input wire logic clk,
    input wire logic drive_on,
    input wire logic fast_decay,
    output logic comp_trip
);
    int cur = 0;
    // current rises when driven, falls in fast decay, holds in slow decay
    always @(posedge clk) begin
        if (drive_on && cur < 1000) cur <= cur + 1;
        else if (fast_decay && cur > 0) cur <= cur - 1;
    end
    // stays tripped through slow decay, so a timer must end it
    assign comp_trip = (cur >= LIM);
endmodule
`default_nettype wire

// ==== testbench/tb_scc_top.sv ====
/*
 Self-checking bench for the two-coil chopper.
 Assumes scc_top, its checker and the bridge model are compiled before.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scc_consts.svh"
module tb_scc_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [`SCC_OFF_W-1:0] off_t = 4'h1;
    logic [1:0] bsel = 2'h3;
    logic [7:0] fast_t = 8'h14, grad = 8'h00, ofs = 8'h00, grad_rb, ofs_rb;
    logic pin = 1'b1, flag = 1'b0, en, cm;
    logic [8:0] scale = 9'h000, scale_rb;
    wire [1:0] trip;
    logic [1:0] drv, slw, fst, blk;
    int failures = 0, checks_done = 0, n;
    wire [3:0] mon = {blk[0], fst[0], slw[0], drv[0]};
    always #20 clk = ~clk;
    scc_top u_scc_top (.CLK(clk), .RESET_N(reset_n),
        .OFF_TIME_SETTING(off_t), .BLANK_TIME_SELECT(bsel),
        .FAST_DECAY_TIME(fast_t), .MODE_PIN(pin), .MODE_FLAG(flag),
        .COMP_TRIP(trip), .REG_SCALE(scale), .REG_GRADIENT(grad),
        .REG_OFFSET(ofs), .DRIVE_ON(drv), .SLOW_DECAY(slw),
        .FAST_DECAY(fst), .BLANKING(blk), .DRIVER_ENABLED(en),
        .CURRENT_MODE(cm), .AUTO_SCALE_READBACK(scale_rb),
        .AUTO_GRADIENT_READBACK(grad_rb), .AUTO_OFFSET_READBACK(ofs_rb));
    // coil 1 trips much later, so its phases drift apart from coil 0
    scc_bridge_model #(.LIM(60)) u_scc_bridge_model (.clk(clk),
        .drive_on(drv[0]), .fast_decay(fst[0]), .comp_trip(trip[0]));
    scc_bridge_model #(.LIM(400)) u_scc_bridge_model_b (.clk(clk),
        .drive_on(drv[1]), .fast_decay(fst[1]), .comp_trip(trip[1]));
    task automatic end_sim();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // inputs move and outputs are read 2 ns after the edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    // bounded wait for a coil 0 monitor bit
    task automatic wait_for(input int k, input logic v);
        int i;
        for (i = 0; i < 2000 && mon[k] !== v; i++) step(1);
        if (i == 2000) begin
            failures++;
            end_sim();
        end
    endtask
    task automatic len(input int k, output int c);
        wait_for(k, 1'b1);
        for (c = 0; c < 2000 && mon[k] === 1'b1; c++) step(1);
    endtask
    task automatic t_cycle();
        wait_for(1, 1'b1);
        cmp(drv[1], 1'b1);
        len(1, n);
        cmp(n, 44);
        len(2, n);
        cmp(n, 21);
        len(1, n);
        cmp(n, 44);
        wait_for(0, 1'b1);
        cmp(blk[0], 1'b1);
    endtask
    task automatic t_blank();
        for (int s = 0; s < 4; s++) begin
            bsel = s[1:0];
            wait_for(0, 1'b0);
            wait_for(0, 1'b1);
            len(3, n);
            cmp(n, 16 + 8 * s);
            len(2, n);
            cmp(n, (s == 0) ? 17 : 21);
        end
    endtask
    // flag change during an on phase, pin change while the bridge is idle, never mid slow decay
    task automatic t_mode();
        scale = 9'h1ab;
        grad = 8'hff;
        ofs = 8'h80;
        step(6);
        cmp(cm, 1'b1);
        cmp(scale_rb, 9'h000);
        cmp(grad_rb, 8'hff);
        cmp(ofs_rb, 8'h80);
        wait_for(0, 1'b1);
        flag = 1'b1;
        step(8);
        cmp(cm, 1'b0);
        cmp(drv, 2'h0);
        cmp(scale_rb, 9'h1ab);
        pin = 1'b0;
        step(8);
        cmp(cm, 1'b1);
    endtask
    // full off time: one chopper period lands inside the audible-safe band
    task automatic t_enable();
        int p;
        wait_for(0, 1'b1);
        off_t = 4'h0;
        step(5);
        cmp(en, 1'b0);
        cmp(drv, 2'h0);
        off_t = 4'hf;
        step(5);
        cmp(en, 1'b1);
        wait_for(0, 1'b0);
        len(0, n);
        p = n;
        len(1, n);
        cmp(n, 492);
        p += n;
        len(2, n);
        p += n;
        len(1, n);
        p += n;
        cmp(p, 1046);
    endtask
    initial begin
        step(10);
        reset_n = 1'b1;
        t_cycle();
        t_blank();
        t_mode();
        t_enable();
        end_sim();
    end
endmodule
`default_nettype wire
